// ===== shared/incdec_pkg.sv
`default_nettype none
package incdec_pkg;
	localparam int DATA_W   = 8;
	localparam int FADDR_W  = 7;
	localparam int PC_W     = 12;
	localparam int OPC_W    = 14;

	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 12'h000;
	localparam logic [DATA_W-1:0] ONE      = 8'h01;
	localparam logic [DATA_W-1:0] ZERO     = 8'h00;
	localparam logic [PC_W-1:0]   PC_STEP  = 12'h001;

	// opcode field positions
	localparam int OP_HI   = 13;
	localparam int OP6_LO  = 8;
	localparam int OP2_LO  = 12;
	localparam int DST_BIT = 7;
	localparam int LIT_HI  = 7;
	localparam int JMP_HI  = 11;

	// upper six bits of the opcode, upper two for the jump
	localparam logic [5:0] OPC_DEC     = 6'h03;
	localparam logic [5:0] OPC_DECSKIP = 6'h0B;
	localparam logic [5:0] OPC_INC     = 6'h0A;
	localparam logic [5:0] OPC_INCSKIP = 6'h0F;
	localparam logic [5:0] OPC_ORLIT   = 6'h1A;
	localparam logic [5:0] OPC_ORREG   = 6'h04;
	localparam logic [5:0] OPC_COPY    = 6'h08;
	localparam logic [1:0] OPC_JUMP    = 2'h3;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_DEC,
		OP_INC,
		OP_OR,
		OP_COPY
	} alu_op_t;
endpackage
`default_nettype wire

// ===== shared/decode_if.sv
`default_nettype none
interface decode_if;
	import incdec_pkg::*;
	logic                valid;
	alu_op_t             op;
	logic                use_lit;
	logic                to_reg;
	logic                skip_zero;
	logic                flag_z;
	logic                jump;
	logic [DATA_W-1:0]   lit;
	logic [PC_W-1:0]     target;
	logic [FADDR_W-1:0]  faddr;
	modport decoder (output valid, op, use_lit, to_reg, skip_zero, flag_z,
		jump, lit, target, faddr);
	modport core (input valid, op, use_lit, to_reg, skip_zero, flag_z,
		jump, lit, target, faddr);
endinterface
`default_nettype wire

// ===== hw/opcode_decoder.sv
`default_nettype none
module opcode_decoder
	import incdec_pkg::*;
(
	input  wire logic [OPC_W-1:0] opcode_i,
	decode_if.decoder             dec
);
	logic [5:0] top6;

	// =========================================================
	// field split and opcode match
	always_comb begin
		top6          = opcode_i[OP_HI:OP6_LO];
		dec.valid     = 1'b1;
		dec.op        = OP_NONE;
		dec.use_lit   = 1'b0;
		dec.to_reg    = opcode_i[DST_BIT];
		dec.skip_zero = 1'b0;
		dec.flag_z    = 1'b0;
		dec.jump      = 1'b0;
		dec.lit       = opcode_i[LIT_HI:0];
		dec.target    = opcode_i[JMP_HI:0];
		dec.faddr     = opcode_i[FADDR_W-1:0];
		if (opcode_i[OP_HI:OP2_LO] == OPC_JUMP) begin
			dec.jump   = 1'b1;
			dec.to_reg = 1'b0;
		end else if (top6 == OPC_DEC) begin
			dec.op     = OP_DEC;
			dec.flag_z = 1'b1;
		end else if (top6 == OPC_DECSKIP) begin
			dec.op        = OP_DEC;
			dec.skip_zero = 1'b1;
		end else if (top6 == OPC_INC) begin
			dec.op     = OP_INC;
			dec.flag_z = 1'b1;
		end else if (top6 == OPC_INCSKIP) begin
			dec.op        = OP_INC;
			dec.skip_zero = 1'b1;
		end else if (top6 == OPC_ORLIT) begin
			dec.op      = OP_OR;
			dec.use_lit = 1'b1;
			dec.to_reg  = 1'b0;
			dec.flag_z  = 1'b1;
		end else if (top6 == OPC_ORREG) begin
			dec.op     = OP_OR;
			dec.flag_z = 1'b1;
		end else if (top6 == OPC_COPY && !opcode_i[DST_BIT]) begin
			// zero flag follows the worked example, not the summary line
			dec.op     = OP_COPY;
			dec.flag_z = 1'b1;
		end else begin
			dec.valid  = 1'b0;
			dec.to_reg = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== hw/incdec_branch_or_execute.sv
`default_nettype none
// Contract
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - The file operand is a 7-bit address and the destination one bit.
// - Decrement subtracts one, routes by destination, sets zero, one cycle.
// - The zero flag is set when an affecting result is zero, else cleared.
// - Decrement-skip keeps the flags and on zero flushes the next opcode.
// - Jump loads the 12-bit field into the program counter, two cycles.
// - Increment adds one, routes by destination, sets zero, one cycle.
// - Increment-skip keeps the flags and on zero flushes the next opcode.
// - Or-literal ors the 8-bit literal into the accumulator, sets zero.
// - Or-register ors accumulator and file, routes it, sets zero.
// - Copy moves the file register to the accumulator, zero on zero.
module incdec_branch_or_execute
	import incdec_pkg::*;
(
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	input  wire logic [incdec_pkg::OPC_W-1:0] opcode_i,
	input  wire logic [incdec_pkg::DATA_W-1:0] freg_rdata_i,
	output logic [incdec_pkg::FADDR_W-1:0]    freg_addr_o,
	output logic                              freg_we_o,
	output logic [incdec_pkg::DATA_W-1:0]     freg_wdata_o,
	output logic [incdec_pkg::DATA_W-1:0]     acc_o,
	output logic                              zero_flag_o,
	output logic [incdec_pkg::PC_W-1:0]       program_counter_o,
	output logic                              flush_o
);
	import incdec_pkg::*;

	decode_if dec ();

	logic [DATA_W-1:0] acc;
	logic              zero_flag;
	logic [PC_W-1:0]   program_counter;
	logic              flushing;
	logic [DATA_W-1:0] wdata;
	logic              we;
	logic [DATA_W-1:0] next_acc;
	logic              next_zero_flag;
	logic [PC_W-1:0]   next_program_counter;
	logic              next_flushing;
	logic [DATA_W-1:0] next_wdata;
	logic              next_we;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] bit_clear;
	logic              result_zero;
	logic              live;
	logic              act;
	logic              take_jump;

	// =========================================================
	// decode
	opcode_decoder u_decoder (
		.opcode_i (opcode_i),
		.dec      (dec)
	);

	// the address goes straight out so the read data is back this cycle
	assign freg_addr_o = dec.faddr;

	// =========================================================
	// slot qualifiers
	// a flushed slot behaves as no_operation; only the program counter steps
	always_comb begin
		live      = !flushing && dec.valid;
		take_jump = !flushing && dec.jump;
		act       = live && (dec.op != OP_NONE);
	end

	// =========================================================
	// arithmetic and logic unit
	// one 8-bit path, so increment and decrement wrap naturally
	always_comb begin
		operand = dec.use_lit ? dec.lit : freg_rdata_i;
		result  = ZERO;
		case (dec.op)
			OP_DEC: begin
				result = freg_rdata_i - ONE;
			end
			OP_INC: begin
				result = freg_rdata_i + ONE;
			end
			OP_OR: begin
				result = acc | operand;
			end
			OP_COPY: begin
				result = freg_rdata_i;
			end
			default: begin
				result = ZERO;
			end
		endcase
	end

	// =========================================================
	// zero detect
	// per-bit clear test, folded by one reduction
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_zero
			assign bit_clear[gi] = !result[gi];
		end
	endgenerate

	assign result_zero = &bit_clear;

	// =========================================================
	// accumulator
	// destination bit low, or any literal form, lands here
	always_comb begin
		next_acc = acc;
		if (act && !dec.to_reg) begin
			next_acc = result;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			acc <= ACC_RST;
		end else begin
			acc <= next_acc;
		end
	end

	// =========================================================
	// zero flag
	// skip forms and jumps leave the flag alone
	always_comb begin
		next_zero_flag = zero_flag;
		if (act && dec.flag_z) begin
			next_zero_flag = result_zero;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			zero_flag <= 1'b0;
		end else begin
			zero_flag <= next_zero_flag;
		end
	end

	// =========================================================
	// program counter
	// steps every cycle, flushed slots included, unless a jump lands
	always_comb begin
		next_program_counter = program_counter + PC_STEP;
		if (take_jump) begin
			next_program_counter = dec.target;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			program_counter <= PC_RST;
		end else begin
			program_counter <= next_program_counter;
		end
	end

	// =========================================================
	// flush slot
	// the prefetched word is stale after a jump or a taken skip,
	// so exactly one following slot is dropped
	always_comb begin
		next_flushing = 1'b0;
		if (take_jump) begin
			next_flushing = 1'b1;
		end else if (act && dec.skip_zero && result_zero) begin
			next_flushing = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flushing <= 1'b0;
		end else begin
			flushing <= next_flushing;
		end
	end

	// =========================================================
	// file register write-back
	// registered, so the far side must keep the address one cycle
	always_comb begin
		next_we    = 1'b0;
		next_wdata = wdata;
		if (act && dec.to_reg) begin
			next_we    = 1'b1;
			next_wdata = result;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wdata <= ZERO;
			we    <= 1'b0;
		end else begin
			wdata <= next_wdata;
			we    <= next_we;
		end
	end

	// =========================================================
	// outputs
	assign acc_o             = acc;
	assign zero_flag_o       = zero_flag;
	assign program_counter_o = program_counter;
	assign flush_o           = flushing;
	assign freg_we_o         = we;
	assign freg_wdata_o      = wdata;
endmodule
`default_nettype wire

// ===== tb/freg_model.sv
`default_nettype none
module freg_model
	import incdec_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic [FADDR_W-1:0] addr_i,
	input  wire logic               we_i,
	input  wire logic [DATA_W-1:0]  wdata_i,
	output logic      [DATA_W-1:0]  rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0]  mem [128];
	logic [FADDR_W-1:0] addr_q;
	// =====
	// write lands one edge late, so keep the issuing address
	always @(posedge clk_i) begin
		addr_q <= addr_i;
		if (we_i)
			mem[addr_q] <= wdata_i;
	end
	assign rdata_o = mem[addr_i];
endmodule
`default_nettype wire

// ===== tb/incdec_assertions.sv
`default_nettype none
module incdec_checker
	import incdec_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               sys_rst_i,
	input wire logic [OPC_W-1:0]   opcode_i,
	input wire logic [DATA_W-1:0]  freg_rdata_i,
	input wire logic [FADDR_W-1:0] freg_addr_o,
	input wire logic               freg_we_o,
	input wire logic [DATA_W-1:0]  freg_wdata_o,
	input wire logic [DATA_W-1:0]  acc_o,
	input wire logic               zero_flag_o,
	input wire logic [PC_W-1:0]    program_counter_o,
	input wire logic               flush_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// =====
	// decode helpers; a flushed slot executes nothing
	wire [5:0] op = opcode_i[13:8];
	wire       go = !flush_o;
	wire       d  = opcode_i[DST_BIT];
	wire       jmp = opcode_i[13:12] == OPC_JUMP;
	sequence s_flush_once;
		flush_o ##1 !flush_o;
	endsequence
	a_dec_zero: assert property (go && op == OPC_DEC && freg_rdata_i == ONE
		|=> zero_flag_o) else $error("decrement of one left zero clear");
	a_dec_to_acc: assert property (go && op == OPC_DEC && !d |=> !freg_we_o
		&& acc_o == $past(freg_rdata_i) - ONE) else $error("bad decrement");
	a_inc_to_reg: assert property (go && op == OPC_INC && d |=> freg_we_o
		&& freg_wdata_o == $past(freg_rdata_i) + ONE) else $error("bad inc");
	a_skip_flush: assert property (go && ((op == OPC_DECSKIP &&
		freg_rdata_i == ONE) || (op == OPC_INCSKIP && freg_rdata_i == 8'hFF))
		|=> s_flush_once) else $error("zero skip did not flush once");
	a_skip_flags: assert property (go && (op == OPC_DECSKIP ||
		op == OPC_INCSKIP) |=> $stable(zero_flag_o)) else $error("skip flag");
	a_jump_load: assert property (go && jmp |=> flush_o &&
		program_counter_o == $past(opcode_i[JMP_HI:0])) else $error("jump");
	a_pc_step: assert property (!go || !jmp |=> program_counter_o ==
		$past(program_counter_o) + PC_STEP) else $error("pc step");
	a_or_lit: assert property (go && op == OPC_ORLIT |=>
		acc_o == ($past(acc_o) | $past(opcode_i[LIT_HI:0])))
		else $error("or literal");
	a_copy_acc: assert property (go && op == OPC_COPY && !d |=>
		acc_o == $past(freg_rdata_i)) else $error("copy");
	a_flush_hold: assert property (flush_o |=> $stable(acc_o) &&
		!freg_we_o) else $error("flushed slot acted");
endmodule
bind incdec_branch_or_execute incdec_checker u_chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .opcode_i(opcode_i), .freg_rdata_i(freg_rdata_i),
	.freg_addr_o(freg_addr_o), .freg_we_o(freg_we_o),
	.freg_wdata_o(freg_wdata_o), .acc_o(acc_o), .zero_flag_o(zero_flag_o),
	.program_counter_o(program_counter_o), .flush_o(flush_o));
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
	import incdec_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk_i, sys_rst_i, we, zf, fl;
	logic [OPC_W-1:0]   opcode_i;
	logic [FADDR_W-1:0] addr;
	logic [DATA_W-1:0]  rdata, wdata, acc;
	logic [PC_W-1:0]    pc;
	int                 errors = 0, comparisons = 0;
	// =====
	incdec_branch_or_execute u_incdec_branch_or_execute (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .opcode_i(opcode_i), .freg_rdata_i(rdata),
		.freg_addr_o(addr), .freg_we_o(we), .freg_wdata_o(wdata), .acc_o(acc),
		.zero_flag_o(zf), .program_counter_o(pc), .flush_o(fl));
	freg_model u_freg_model (.clk_i(clk_i), .addr_i(addr), .we_i(we),
		.wdata_i(wdata), .rdata_o(rdata));
	task automatic check(string n, logic [11:0] e, logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// one opcode per cycle, results settled on return
	task automatic issue(logic [13:0] op);
		opcode_i = op;
		@(posedge clk_i);
		#1;
	endtask
	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// =====
	task automatic t_incdec;
		u_freg_model.mem[5] = ONE;
		u_freg_model.mem[6] = ZERO;
		u_freg_model.mem[7] = 8'hFF;
		u_freg_model.mem[13] = 8'hFF;
		issue({OPC_DEC, 1'b1, 7'h05});
		check("zero", 1, zf);
		check("we", 1, we);
		check("wdata", ZERO, wdata);
		issue({OPC_DEC, 1'b0, 7'h06});
		check("reg", ZERO, u_freg_model.mem[5]);
		check("acc", 8'hFF, acc);
		check("zero", 0, zf);
		check("we", 0, we);
		issue({OPC_INC, 1'b0, 7'h07});
		check("acc", ZERO, acc);
		check("zero", 1, zf);
		check("reg", ZERO, u_freg_model.mem[6]);
		issue({OPC_INC, 1'b1, 7'h0D});
		check("we", 1, we);
		check("wdata", ZERO, wdata);
		check("acc", ZERO, acc);
	endtask
	// copy with the destination bit set is refused and changes nothing
	task automatic t_or_copy;
		u_freg_model.mem[8] = 8'h13;
		u_freg_model.mem[9] = ZERO;
		u_freg_model.mem[14] = 8'h5A;
		issue({OPC_ORLIT, 8'h35});
		check("acc", 8'h35, acc);
		check("zero", 0, zf);
		check("reg", ZERO, u_freg_model.mem[13]);
		issue({OPC_ORREG, 1'b1, 7'h08});
		check("wdata", 8'h37, wdata);
		check("acc", 8'h35, acc);
		issue({OPC_COPY, 1'b0, 7'h09});
		check("reg", 8'h37, u_freg_model.mem[8]);
		check("zero", 1, zf);
		check("acc", ZERO, acc);
		issue({OPC_COPY, 1'b1, 7'h0E});
		check("acc", ZERO, acc);
		check("we", 0, we);
		issue({OPC_ORREG, 1'b0, 7'h0E});
		check("acc", 8'h5A, acc);
		check("zero", 0, zf);
	endtask
	// a zero skip swallows the next opcode, a non-zero one does not
	task automatic t_skip;
		u_freg_model.mem[10] = ONE;
		u_freg_model.mem[11] = ONE;
		u_freg_model.mem[12] = 8'hFF;
		u_freg_model.mem[15] = 8'h03;
		issue({OPC_DECSKIP, 1'b1, 7'h0A});
		check("flush", 1, fl);
		check("zero", 0, zf);
		issue({OPC_ORLIT, 8'hF0});
		check("acc", 8'h5A, acc);
		check("flush", 0, fl);
		check("reg", ZERO, u_freg_model.mem[10]);
		issue({OPC_DECSKIP, 1'b0, 7'h0F});
		check("acc", 8'h02, acc);
		check("flush", 0, fl);
		issue({OPC_INCSKIP, 1'b0, 7'h0B});
		check("flush", 0, fl);
		issue({OPC_ORLIT, 8'h40});
		check("acc", 8'h42, acc);
		issue({OPC_INCSKIP, 1'b0, 7'h0C});
		check("flush", 1, fl);
		check("zero", 0, zf);
		issue({OPC_ORLIT, 8'h01});
		check("acc", ZERO, acc);
	endtask
	task automatic t_jump;
		issue({OPC_JUMP, 12'hFFF});
		check("pc", 12'hFFF, pc);
		check("flush", 1, fl);
		issue({OPC_ORLIT, 8'h80});
		check("acc", ZERO, acc);
		check("pc", 12'h000, pc);
		issue({OPC_JUMP, 12'h123});
		check("pc", 12'h123, pc);
		check("zero", 0, zf);
	endtask
	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	// the run needs about 30 cycles; 600 is ample
	initial begin
		#4800;
		errors++;
		summarize();
	end
	initial begin
		sys_rst_i = 1;
		opcode_i = '0;
		repeat (10) @(posedge clk_i);
		#1 sys_rst_i = 0;
		check("acc", ACC_RST, acc);
		check("pc", PC_RST, pc);
		check("flush", 0, fl);
		check("zero", 0, zf);
		t_incdec();
		t_or_copy();
		t_skip();
		t_jump();
		summarize();
	end
endmodule
`default_nettype wire
